//--- verilog/sqf_top.sv
// serial master word queues, receive flags, interrupt and wishbone slave
`timescale 1ns/1ps
`default_nettype none
module sqf_top #(
  parameter int WORD_BITS = sqf_pkg::WORD_BITS_DEF
) (
  // clock and reset
  input  wire logic                   i_clk,
  input  wire logic                   i_reset,
  // wishbone slave
  input  wire sqf_pkg::sqf_wb_req_type i_wb,
  output logic                        o_wb_ack,
  output logic [31:0]                 o_wb_dat,
  // interrupt
  output logic                        o_irq,
  // serial link
  input  wire logic                   i_bit_clk,
  input  wire logic                   i_miso,
  output logic                        o_sclk,
  output logic                        o_mosi,
  output logic                        o_ss_n
);
  import sqf_pkg::*;

  // path width picked at build time from the word length
  localparam int DATA_W = (WORD_BITS <= NARROW_PATH) ? NARROW_PATH
                                                     : WIDE_PATH;

  typedef enum logic [1:0] {
    ST_IDLE  = 2'b01,
    ST_SHIFT = 2'b10
  } sqf_state_type;

  ////////////////////////////////////////////////////////////////////////////
  // declarations
  logic                  bclk_s1_q;
  logic                  bclk_s2_q;
  logic                  bclk_prev_q;
  logic                  miso_s1_q;
  logic                  miso_s2_q;
  logic                  tick;

  sqf_state_type         st_q;
  logic [WORD_BITS-1:0]  tx_sh_q;
  logic [WORD_BITS-1:0]  rx_sh_q;
  logic [BIT_CNT_W-1:0]  bit_cnt_q;
  logic                  word_end;

  logic                  req;
  logic                  tx_push;
  logic                  tx_pop;
  logic [DATA_W-1:0]     tx_data;
  logic [CNT_W-1:0]      tx_count;
  logic                  tx_full;
  logic                  tx_empty;
  logic                  rx_push;
  logic                  rx_pop;
  logic [DATA_W-1:0]     rx_data;
  logic [CNT_W-1:0]      rx_count;
  logic                  rx_full;
  logic                  rx_empty;

  logic                  stat_rd;
  logic                  ovf_evt;
  logic                  ovf_q;
  logic [FLAG_W-1:0]     mask_q;
  sqf_rx_flags_type      flags;

  function automatic logic hit(input logic [7:0] adr,
                               input logic [7:0] reg_adr);
    hit = (adr == reg_adr);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // link input synchronisers
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      bclk_s1_q   <= 1'b0;
      bclk_s2_q   <= 1'b0;
      bclk_prev_q <= 1'b0;
      miso_s1_q   <= 1'b0;
      miso_s2_q   <= 1'b0;
    end else begin
      bclk_s1_q   <= i_bit_clk;
      bclk_s2_q   <= bclk_s1_q;
      bclk_prev_q <= bclk_s2_q;
      miso_s1_q   <= i_miso;
      miso_s2_q   <= miso_s1_q;
    end
  end

  // one step per bit clock rise, so the bit rate is half that clock
  assign tick = bclk_s2_q & ~bclk_prev_q;

  ////////////////////////////////////////////////////////////////////////////
  // queues
  sqf_word_queue #(.WIDTH(DATA_W)) u_tx_queue (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_push  (tx_push),
    .i_data  (i_wb.dat[DATA_W-1:0]),
    .i_pop   (tx_pop),
    .o_data  (tx_data),
    .o_count (tx_count),
    .o_full  (tx_full),
    .o_empty (tx_empty)
  );

  sqf_word_queue #(.WIDTH(DATA_W)) u_rx_queue (
    .i_clk   (i_clk),
    .i_reset (i_reset),
    .i_push  (rx_push),
    .i_data  (DATA_W'(rx_sh_q)),
    .i_pop   (rx_pop),
    .o_data  (rx_data),
    .o_count (rx_count),
    .o_full  (rx_full),
    .o_empty (rx_empty)
  );

  ////////////////////////////////////////////////////////////////////////////
  // shift engine, mode 0: drive on sclk fall, sample on rise
  assign word_end = tick & o_sclk & (st_q == ST_SHIFT)
                  & (bit_cnt_q == BIT_CNT_W'(WORD_BITS));
  // a word starts from idle, or follows at once while words remain
  assign tx_pop   = ~tx_empty & tick
                  & ((st_q == ST_IDLE) | word_end);
  assign rx_push  = word_end;
  assign ovf_evt  = rx_push & rx_full;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      st_q      <= ST_IDLE;
      o_sclk    <= 1'b0;
      o_mosi    <= 1'b0;
      o_ss_n    <= 1'b1;
      tx_sh_q   <= '0;
      rx_sh_q   <= '0;
      bit_cnt_q <= '0;
    end else begin
      unique case (st_q)
        ST_IDLE: begin
          if (tx_pop) begin
            st_q      <= ST_SHIFT;
            o_ss_n    <= 1'b0;
            tx_sh_q   <= tx_data[WORD_BITS-1:0];
            o_mosi    <= tx_data[WORD_BITS-1];
            bit_cnt_q <= '0;
          end
        end
        ST_SHIFT: begin
          if (tick && !o_sclk) begin
            o_sclk    <= 1'b1;
            rx_sh_q   <= {rx_sh_q[WORD_BITS-2:0], miso_s2_q};
            bit_cnt_q <= bit_cnt_q + BIT_CNT_W'(1);
          end else if (tick) begin
            o_sclk <= 1'b0;
            if (tx_pop) begin
              tx_sh_q   <= tx_data[WORD_BITS-1:0];
              o_mosi    <= tx_data[WORD_BITS-1];
              bit_cnt_q <= '0;
            end else if (word_end) begin
              // queue drained: release select and wait for data
              st_q   <= ST_IDLE;
              o_ss_n <= 1'b1;
            end else begin
              tx_sh_q <= {tx_sh_q[WORD_BITS-2:0], 1'b0};
              o_mosi  <= tx_sh_q[WORD_BITS-2];
            end
          end
        end
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // wishbone slave: one wait state, every address acknowledged
  assign req     = i_wb.cyc & i_wb.stb & ~o_wb_ack;
  // processor and dma both reach the queue through this one decode
  assign tx_push = req & i_wb.we & hit(i_wb.adr, ADR_TXDATA)
                 & (|i_wb.sel);
  assign rx_pop  = req & ~i_wb.we & hit(i_wb.adr, ADR_RXDATA);
  assign stat_rd = req & ~i_wb.we & hit(i_wb.adr, ADR_STATUS);

  // live flags full and has_data are plain decodes of the queue state; overflow comes from the sticky ovf_q
  assign flags.full     = rx_full;
  assign flags.has_data = ~rx_empty;
  assign flags.overflow = ovf_q;

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_wb_ack <= 1'b0;
      o_wb_dat <= '0;
    end else begin
      o_wb_ack <= req;
      o_wb_dat <= '0;
      if (req && !i_wb.we) begin
        unique case (1'b1)
          hit(i_wb.adr, ADR_STATUS): o_wb_dat <= 32'(flags);
          hit(i_wb.adr, ADR_MASK):   o_wb_dat <= 32'(mask_q);
          hit(i_wb.adr, ADR_RXDATA): o_wb_dat <= 32'(rx_data);
          default:                   o_wb_dat <= '0;
        endcase
      end
    end
  end

  // mask register; status has no write path at all
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      mask_q <= MASK_RESET;
    end else if (req && i_wb.we && hit(i_wb.adr, ADR_MASK)
                 && i_wb.sel[0]) begin
      mask_q <= i_wb.dat[FLAG_W-1:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // sticky overflow: a new event in the clearing read's cycle survives
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      ovf_q <= STICKY_RESET;
    end else begin
      ovf_q <= ovf_evt | (ovf_q & ~stat_rd);
    end
  end

  // interrupt lags the flags by one cycle to come from a flop
  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      o_irq <= 1'b0;
    end else begin
      o_irq <= |(FLAG_W'(flags) & mask_q);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (i_reset);

  chk_word_length_range: assert property (
    WORD_BITS >= WORD_BITS_MIN && WORD_BITS <= WORD_BITS_MAX)
    else $error("word length outside three to sixteen");

  chk_status_write_ignored: assert property (
    (req && i_wb.we && hit(i_wb.adr, ADR_STATUS) && !ovf_evt)
    |=> ovf_q == $past(ovf_q))
    else $error("write to status changed a flag");

  chk_irq_masked_or: assert property (
    (mask_q[FLAG_HAS_DATA] && !rx_empty) [*2] |-> o_irq)
    else $error("enabled has-data flag gave no interrupt");

  chk_irq_all_masked: assert property (
    (mask_q == '0) [*2] |-> !o_irq)
    else $error("interrupt with every flag masked");

  chk_sticky_read_clear: assert property (
    (stat_rd && !ovf_evt) |=> !ovf_q)
    else $error("status read left overflow set");

  chk_sticky_holds: assert property (
    (ovf_q && !stat_rd) |=> ovf_q)
    else $error("overflow cleared without a read");

  chk_read_keeps_live: assert property (
    (stat_rd && !rx_push) |=> rx_count == $past(rx_count))
    else $error("status read changed receive queue");

  chk_full_flag_rise: assert property (
    (rx_push && rx_count == CNT_W'(QUEUE_DEPTH - 1) && !rx_pop)
    |=> rx_full ##1 o_wb_dat[FLAG_FULL] || !$past(stat_rd))
    else $error("receive queue of four not flagged full");

  chk_has_data_read: assert property (
    stat_rd |=> o_wb_ack && o_wb_dat[FLAG_HAS_DATA] == !$past(rx_empty))
    else $error("has-data flag read back wrong");

  chk_overflow_set: assert property (
    (rx_push && rx_full) |=> ovf_q ##1 (ovf_q || $past(stat_rd)))
    else $error("word into full queue did not set overflow");

  chk_tx_queue_push: assert property (
    (tx_push && !tx_full && !tx_pop)
    |=> tx_count == $past(tx_count) + CNT_W'(1))
    else $error("transmit write not queued");

  chk_tx_stops_empty: assert property (
    (st_q == ST_IDLE && tx_empty) |=> (st_q == ST_IDLE && o_ss_n))
    else $error("shifting started with empty transmit queue");

  chk_rx_read_pops: assert property (
    (rx_pop && !rx_empty && !rx_push)
    |=> rx_count == $past(rx_count) - CNT_W'(1)
        && o_wb_dat[DATA_W-1:0] == $past(rx_data))
    else $error("receive read did not return and remove oldest word");

endmodule
`default_nettype wire

//--- verilog/sqf_pkg.sv
// shared constants and types for the serial queue and flag block
package sqf_pkg;

  ////////////////////////////////////////////////////////////////////////////
  // word sizing
  localparam int QUEUE_DEPTH   = 4;
  localparam int PTR_W         = 2;
  localparam int CNT_W         = 3;
  localparam int WORD_BITS_DEF = 8;
  localparam int WORD_BITS_MIN = 3;
  localparam int WORD_BITS_MAX = 16;
  localparam int NARROW_PATH   = 8;
  localparam int WIDE_PATH     = 16;
  localparam int BIT_CNT_W     = 5;

  ////////////////////////////////////////////////////////////////////////////
  // register byte addresses
  localparam logic [7:0] ADR_STATUS = 8'h00;
  localparam logic [7:0] ADR_MASK   = 8'h04;
  localparam logic [7:0] ADR_TXDATA = 8'h08;
  localparam logic [7:0] ADR_RXDATA = 8'h0C;

  ////////////////////////////////////////////////////////////////////////////
  // receive flag layout and reset values
  localparam int         FLAG_FULL     = 0;
  localparam int         FLAG_HAS_DATA = 1;
  localparam int         FLAG_OVERFLOW = 2;
  localparam int         FLAG_W        = 3;
  localparam logic [2:0] MASK_RESET    = 3'h0;
  localparam logic       STICKY_RESET  = 1'h0;

  typedef struct packed {
    logic overflow;
    logic has_data;
    logic full;
  } sqf_rx_flags_type;

  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } sqf_wb_req_type;

endpackage

//--- verilog/sqf_word_queue.sv
// four-entry word queue used for both transmit and receive
`timescale 1ns/1ps
`default_nettype none
module sqf_word_queue #(
  parameter int WIDTH = 8
) (
  // clock and reset
  input  wire logic                      i_clk,
  input  wire logic                      i_reset,
  // fill side
  input  wire logic                      i_push,
  input  wire logic [WIDTH-1:0]          i_data,
  // drain side
  input  wire logic                      i_pop,
  output logic      [WIDTH-1:0]          o_data,
  // state
  output logic      [sqf_pkg::CNT_W-1:0] o_count,
  output logic                           o_full,
  output logic                           o_empty
);
  import sqf_pkg::*;

  logic [WIDTH-1:0] mem_q [QUEUE_DEPTH];
  logic [PTR_W-1:0] wr_q;
  logic [PTR_W-1:0] rd_q;
  logic [CNT_W-1:0] cnt_q;
  logic             push_ok;
  logic             pop_ok;

  assign o_full  = (cnt_q == CNT_W'(QUEUE_DEPTH));
  assign o_empty = (cnt_q == '0);
  assign o_count = cnt_q;
  assign o_data  = mem_q[rd_q];
  // a push into a full queue is dropped, old words stay
  assign push_ok = i_push & ~o_full;
  assign pop_ok  = i_pop & ~o_empty;

  ////////////////////////////////////////////////////////////////////////////
  // storage has no reset; only the pointers define content
  always_ff @(posedge i_clk) begin
    if (push_ok) begin
      mem_q[wr_q] <= i_data;
    end
  end

  always_ff @(posedge i_clk or posedge i_reset) begin
    if (i_reset) begin
      wr_q  <= '0;
      rd_q  <= '0;
      cnt_q <= '0;
    end else begin
      if (push_ok) begin
        wr_q <= wr_q + PTR_W'(1);
      end
      if (pop_ok) begin
        rd_q <= rd_q + PTR_W'(1);
      end
      cnt_q <= cnt_q + CNT_W'(push_ok) - CNT_W'(pop_ok);
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  chk_full_keeps_words: assert property (
    @(posedge i_clk) disable iff (i_reset)
    (o_full && i_push && !i_pop) |=> (o_full && wr_q == $past(wr_q)))
    else $error("push into full queue changed its contents");

endmodule
`default_nettype wire

//--- verification/sqf_slave_model.sv
// behavioural serial slave answering the master in mode 0
`timescale 1ns/1ps
`default_nettype none
module sqf_slave_model #(
  parameter int WORD_BITS = 8
) (
  // serial pins
  input  wire logic        i_sclk,
  input  wire logic        i_mosi,
  input  wire logic        i_ss_n,
  // reply seed and last word seen
  input  wire logic [15:0] i_reply,
  output logic             o_miso,
  output logic [15:0]      o_got
);
  logic [15:0] reply_q;
  logic [15:0] shift_q;
  int          idx;
  int          ndone;
  initial begin
    o_miso  = 1'b0;
    o_got   = 16'h0000;
    shift_q = 16'h0000;
    ndone   = 0;
  end
  ////////////////////////////////////////////////////////////////////////////
  // reply k is seed plus k, counted over finished words only, so a
  // reload at the closing edge of a frame never skips a value
  task automatic load_word();
    reply_q = i_reply + 16'(ndone);
    idx     = WORD_BITS - 1;
    o_miso  = reply_q[idx];
  endtask
  always @(negedge i_ss_n) begin
    load_word();
  end
  always @(posedge i_sclk) begin
    if (!i_ss_n) begin
      shift_q = {shift_q[14:0], i_mosi};
    end
  end
  // sclk only falls inside a frame; the last fall shares its edge with
  // the select release, so select must not gate the word count here
  always @(negedge i_sclk) begin
    if (idx == 0) begin
      o_got = shift_q;
      ndone = ndone + 1;
      load_word();
    end else begin
      idx    = idx - 1;
      o_miso = reply_q[idx];
    end
  end
  // no pull on the line: a released pin must not look like held data
  always @(posedge i_ss_n) begin
    o_miso = ~o_miso;
  end
endmodule
`default_nettype wire

//--- verification/sqf_top_bench.sv
// self-checking bench for the serial queue and flag block
`timescale 1ns/1ps
`default_nettype none
module sqf_top_bench;
  import sqf_pkg::*;
  logic           clk     = 1'b0;
  logic           rst     = 1'b1;
  logic           bit_clk = 1'b0;
  sqf_wb_req_type wb      = '0;
  logic [15:0]    reply   = 16'h5A3C;
  logic           ack;
  logic [31:0]    rdat;
  logic           irq;
  logic           miso;
  logic           sclk;
  logic           mosi;
  logic           ss_n;
  logic [15:0]    got;
  int             err_count = 0;
  int             n_tests   = 0;

  always #12.5 clk = ~clk;
  initial begin
    #7;
    forever #100 bit_clk = ~bit_clk;
  end

  sqf_top #(.WORD_BITS(8)) sqf_top_inst (
    .i_clk(clk), .i_reset(rst), .i_wb(wb), .o_wb_ack(ack),
    .o_wb_dat(rdat), .o_irq(irq), .i_bit_clk(bit_clk), .i_miso(miso),
    .o_sclk(sclk), .o_mosi(mosi), .o_ss_n(ss_n));
  sqf_slave_model #(.WORD_BITS(8)) sqf_slave_model_inst (
    .i_sclk(sclk), .i_mosi(mosi), .i_ss_n(ss_n), .i_reply(reply),
    .o_miso(miso), .o_got(got));

  ////////////////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  task automatic check(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      err_count++;
      $display("BAD %s expected %h seen %h", nm, e, g);
    end
  endtask

  // k-th word the slave returned, upper bits of the bus read zero
  function automatic logic [31:0] exp_rx(input int k);
    logic [15:0] t;
    t = reply + 16'(k);
    return {24'h000000, t[7:0]};
  endfunction

  task automatic bus(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
    int n;
    n = 0;
    @(posedge clk);
    wb <= '{1'b1, 1'b1, w, a, 4'hF, d};
    do begin
      @(posedge clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    wb <= '0;
    if (n >= 50) begin
      check("ack", 1, ack);
      wrap_up();
    end
    @(posedge clk);
    check("ack drop", 0, ack);
  endtask

  task automatic wait_ss(input logic lvl, input int lim);
    int n;
    n = 0;
    while (ss_n !== lvl && n < lim) begin
      @(posedge clk);
      n++;
    end
    if (ss_n !== lvl) begin
      check("ss_n wait", lvl, ss_n);
      wrap_up();
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    logic [31:0] q;
    logic [7:0]  w;
    int          nsent;
    nsent = 0;
    q = $urandom(42656);
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    bus(0, ADR_STATUS, 0, q);
    check("status at reset", 0, q);
    bus(0, ADR_MASK, 0, q);
    check("mask at reset", 0, q);
    bus(0, 8'h10, 0, q);
    check("unmapped read", 0, q);
    check("irq at reset", 0, irq);
    $display("test reset values done");
    for (int i = 0; i < 6; i++) begin
      w = 8'($urandom);
      bus(1, ADR_TXDATA, {24'h000000, w}, q);
      wait_ss(0, 200);
      wait_ss(1, 2000);
      check("word on mosi", w, got[7:0]);
      repeat (40) @(posedge clk);
      check("select idle", 1, ss_n);
      check("clock idle", 0, sclk);
      bus(0, ADR_STATUS, 0, q);
      check("status one word", 32'h2, q);
      bus(0, ADR_RXDATA, 0, q);
      check("rx word", exp_rx(nsent), q);
      nsent++;
    end
    $display("test single words done");
    bus(1, ADR_MASK, 32'h4, q);
    for (int i = 0; i < 4; i++) begin
      bus(1, ADR_TXDATA, $urandom & 32'hFF, q);
    end
    wait_ss(0, 200);
    bus(1, ADR_TXDATA, 32'hA5, q);
    wait_ss(1, 4000);
    repeat (4) @(posedge clk);
    check("irq overflow", 1, irq);
    bus(1, ADR_STATUS, 0, q);
    bus(0, ADR_STATUS, 0, q);
    check("status overflow", 32'h7, q);
    bus(0, ADR_STATUS, 0, q);
    check("status after read", 32'h3, q);
    repeat (3) @(posedge clk);
    check("irq cleared", 0, irq);
    bus(1, ADR_MASK, 32'h3, q);
    repeat (3) @(posedge clk);
    check("irq live flags", 1, irq);
    bus(0, ADR_MASK, 0, q);
    check("mask readback", 32'h3, q);
    for (int k = 0; k < 4; k++) begin
      bus(0, ADR_RXDATA, 0, q);
      check("rx oldest", exp_rx(nsent + k), q);
    end
    bus(0, ADR_STATUS, 0, q);
    check("status drained", 0, q);
    repeat (3) @(posedge clk);
    check("irq drained", 0, irq);
    $display("test overflow and interrupt done");
    wrap_up();
  end
endmodule
`default_nettype wire
